/* logic/apg_pkg.sv */
// package: register map, field layout and reset values for the aux pin level block
package apg_pkg;
    localparam int          APG_NUM_PINS       = 6;
    localparam logic [7:0]  APG_LEVEL_REG_ADDR = 8'h17;  // pin_level_register
    localparam logic [7:0]  APG_CFG_REG_ADDR   = 8'h16;  // pin mode / direction register
    localparam int          APG_OUT_LSB        = 8;      // pin_out_level at 13:8
    localparam int          APG_IN_LSB         = 0;      // pin_in_level at 5:0
    localparam int          APG_DIGSEL_LSB     = 8;      // pin_digital_sel at 13:8
    localparam int          APG_DIRSEL_LSB     = 0;      // pin_dir_sel at 5:0
    localparam int          APG_TWSEL_BIT      = 15;     // two_wire_master_sel
    localparam logic [5:0]  APG_OUT_RST        = 6'h00;
    localparam logic [5:0]  APG_IN_RST         = 6'h00;
    localparam logic [5:0]  APG_DIGSEL_RST     = 6'h3F;
    localparam logic [5:0]  APG_DIRSEL_RST     = 6'h00;
    localparam logic        APG_TWSEL_RST      = 1'b0;
endpackage : apg_pkg

/* logic/apg_pin_sync.sv */
// module: two-stage synchroniser for the pin input levels
`timescale 1ns/10ps
module apg_pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("apg_pin_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : apg_pin_sync

/* logic/apg_pin_level.sv */
// module: output drive and input sense of six aux pins with two registers
`timescale 1ns/10ps
// Behaviour
// - six writable output levels at 13:8, reset 0
// - drive only when digital and output selected, except pins 1:0 in two-wire mode
// - two-wire mode ignores out levels 1:0
// - six read-only input levels at 5:0
// - analog pins read input level zero
// - snapshot inputs at address parity end
// - two-wire mode forces input levels 1:0 zero
// - per-pin digital select, default digital
// - per-pin direction select, default input
// - two-wire mode: pin0 data, pin1 clock open-drain
module apg_pin_level (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        addr_parity_end_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic [5:0]  pin_i,
    output logic      [5:0]  pin_o,
    output logic      [5:0]  pin_oe_o,
    input  wire logic        tw_sda_o_i,
    input  wire logic        tw_scl_o_i,
    output logic             tw_sda_in_o
);
    import apg_pkg::*;

    logic [5:0] pin_out_level_r;
    logic [5:0] pin_in_level_r;
    logic [5:0] pin_digital_sel_r;
    logic [5:0] pin_dir_sel_r;
    logic       two_wire_master_sel_r;
    logic [5:0] pin_sync;
    logic [5:0] live_level;
    logic       wr_level;
    logic       wr_cfg;

    // address compare shared by the write decodes and the read mux
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction : addr_hit

    apg_pin_sync #(.WIDTH(APG_NUM_PINS)) u_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (pin_i),
        .sync_o  (pin_sync)
    );

    // write decodes
    assign wr_level = reg_wr_i && addr_hit(reg_addr_i, APG_LEVEL_REG_ADDR);
    assign wr_cfg   = reg_wr_i && addr_hit(reg_addr_i, APG_CFG_REG_ADDR);

    // output level storage; only 13:8 are stored
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_out_level_r <= APG_OUT_RST;
        end else if (wr_level) begin
            pin_out_level_r <= reg_wdata_i[APG_OUT_LSB +: 6];
        end
    end

    // mode, direction and two-wire selects
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_digital_sel_r     <= APG_DIGSEL_RST;
            pin_dir_sel_r         <= APG_DIRSEL_RST;
            two_wire_master_sel_r <= APG_TWSEL_RST;
        end else if (wr_cfg) begin
            pin_digital_sel_r     <= reg_wdata_i[APG_DIGSEL_LSB +: 6];
            pin_dir_sel_r         <= reg_wdata_i[APG_DIRSEL_LSB +: 6];
            two_wire_master_sel_r <= reg_wdata_i[APG_TWSEL_BIT];
        end
    end

    // live sensed level: analog pins zero, pins 1:0 zero in two-wire mode
    always_comb begin
        live_level = pin_sync & pin_digital_sel_r;
        if (two_wire_master_sel_r) begin
            live_level[1:0] = 2'h0;
        end
    end

    // snapshot taken when the address parity bit ends
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_in_level_r <= APG_IN_RST;
        end else if (addr_parity_end_i) begin
            pin_in_level_r <= live_level;
        end
    end

    // pin drivers; input buffer stays live in output mode
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_o    <= 6'h00;
            pin_oe_o <= 6'h00;
        end else begin
            for (int i = 0; i < APG_NUM_PINS; i++) begin
                pin_o[i]    <= pin_out_level_r[i];
                pin_oe_o[i] <= pin_digital_sel_r[i] & pin_dir_sel_r[i];
            end
            if (two_wire_master_sel_r) begin
                pin_o[1:0]  <= 2'h0;
                pin_oe_o[0] <= ~tw_sda_o_i;
                pin_oe_o[1] <= ~tw_scl_o_i;
            end
        end
    end

    // data line read back for the two-wire master
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tw_sda_in_o <= 1'b1;
        end else begin
            tw_sda_in_o <= pin_sync[0];
        end
    end

    // read data for the addressed register, unused bits zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (addr_hit(reg_addr_i, APG_CFG_REG_ADDR)) begin
            reg_rdata_o <= {two_wire_master_sel_r, 1'b0, pin_digital_sel_r, 2'h0, pin_dir_sel_r};
        end else if (addr_hit(reg_addr_i, APG_LEVEL_REG_ADDR)) begin
            reg_rdata_o <= {2'h0, pin_out_level_r, 2'h0, pin_in_level_r};
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // checks on drive gating, input snapshot and register contents
    property p_drive_gate;
        @(posedge clock_i) disable iff (reset_i)
        (!two_wire_master_sel_r && !$past(two_wire_master_sel_r) && !$past(reset_i))
            |-> (pin_oe_o == $past(pin_digital_sel_r & pin_dir_sel_r));
    endproperty
    a_drive_gate: assert property (p_drive_gate) else $error("drive enable wrong");

    property p_tw_ignore;
        @(posedge clock_i) disable iff (reset_i)
        $past(two_wire_master_sel_r) && !$past(reset_i) |-> (pin_o[1:0] == 2'h0);
    endproperty
    a_tw_ignore: assert property (p_tw_ignore) else $error("out level used in two-wire mode");

    property p_snapshot;
        @(posedge clock_i) disable iff (reset_i)
        addr_parity_end_i |=> (pin_in_level_r == $past(live_level));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

    property p_hold;
        @(posedge clock_i) disable iff (reset_i)
        !addr_parity_end_i |=> $stable(pin_in_level_r);
    endproperty
    a_hold: assert property (p_hold) else $error("snapshot changed outside capture");

    property p_analog_zero;
        @(posedge clock_i) disable iff (reset_i)
        ((pin_in_level_r & ~$past(pin_digital_sel_r)) == 6'h00) or !$past(addr_parity_end_i);
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_tw_read_zero;
        @(posedge clock_i) disable iff (reset_i)
        addr_parity_end_i && two_wire_master_sel_r |=> (pin_in_level_r[1:0] == 2'h0);
    endproperty
    a_tw_read_zero: assert property (p_tw_read_zero) else $error("pins 1:0 not zero");

    property p_write_out;
        @(posedge clock_i) disable iff (reset_i)
        wr_level |=> ##1 ($past(reg_addr_i) != APG_LEVEL_REG_ADDR || $past(wr_level, 2) == 1'b0 ||
                          reg_rdata_o[13:8] == $past(reg_wdata_i[13:8], 2) || $past(wr_level));
    endproperty
    a_write_out: assert property (p_write_out) else $error("out level not stored");

    property p_unused_zero;
        @(posedge clock_i) disable iff (reset_i)
        $past(reg_addr_i) == APG_LEVEL_REG_ADDR && !$past(reset_i)
            |-> (reg_rdata_o[15:14] == 2'h0 && reg_rdata_o[7:6] == 2'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

    property p_tw_pins;
        @(posedge clock_i) disable iff (reset_i)
        two_wire_master_sel_r ##1 two_wire_master_sel_r |-> (pin_oe_o[1] == !$past(tw_scl_o_i));
    endproperty
    a_tw_pins: assert property (p_tw_pins) else $error("clock line not open-drain");

    property p_tw_data;
        @(posedge clock_i) disable iff (reset_i)
        two_wire_master_sel_r ##1 two_wire_master_sel_r |-> (pin_oe_o[0] == !$past(tw_sda_o_i));
    endproperty
    a_tw_data: assert property (p_tw_data) else $error("data line not open-drain");

    property p_out_follow;
        @(posedge clock_i) disable iff (reset_i)
        !$past(two_wire_master_sel_r) && !$past(reset_i) |-> (pin_o == $past(pin_out_level_r));
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("pin level not stored level");

    property p_cfg_store;
        @(posedge clock_i) disable iff (reset_i)
        wr_cfg |=> (pin_digital_sel_r == $past(reg_wdata_i[APG_DIGSEL_LSB +: 6]) &&
                    pin_dir_sel_r == $past(reg_wdata_i[APG_DIRSEL_LSB +: 6]));
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("mode or direction not stored");

    property p_sda_echo;
        @(posedge clock_i) disable iff (reset_i)
        !$past(reset_i) |-> (tw_sda_in_o == $past(pin_sync[0]));
    endproperty
    a_sda_echo: assert property (p_sda_echo) else $error("data line level not returned");

    // scenarios that the bench is expected to reach
    c_capture: cover property (@(posedge clock_i) disable iff (reset_i) addr_parity_end_i);
    c_tw_data: cover property (@(posedge clock_i) disable iff (reset_i) two_wire_master_sel_r && pin_oe_o[0]);
    c_level_rd: cover property (@(posedge clock_i) disable iff (reset_i)
                                addr_parity_end_i && reg_addr_i == APG_LEVEL_REG_ADDR);
    c_drive:   cover property (@(posedge clock_i) disable iff (reset_i) pin_oe_o != 6'h00);
    c_tw_mode: cover property (@(posedge clock_i) disable iff (reset_i) two_wire_master_sel_r);
endmodule : apg_pin_level

/* bench/apg_ext_pins.sv */
// partner model: outside circuitry and pull-downs on the six aux pin wires
`timescale 1ns/10ps
module apg_ext_pins (
    input  wire logic [5:0] pin_o_i,
    input  wire logic [5:0] pin_oe_i,
    input  wire logic [5:0] ext_val_i,
    input  wire logic [5:0] ext_en_i,
    output logic      [5:0] level_o
);
    // device drive wins, then the outside driver, else the weak pull-down
    always_comb begin
        for (int n = 0; n < 6; n++) begin
            level_o[n] = pin_oe_i[n] ? pin_o_i[n] : (ext_en_i[n] ? ext_val_i[n] : 1'b0);
        end
    end
endmodule : apg_ext_pins

/* bench/tb_top.sv */
// testbench: register access, pin drive and pin sense of the aux pin block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import apg_pkg::*;
    logic        clock_i = 0, reset_i = 1, reg_wr_i = 0, addr_parity_end_i = 0;
    logic        tw_sda_o_i = 1, tw_scl_o_i = 1, tw_sda_in_o;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic [5:0]  pin_i, pin_o, pin_oe_o, ext_val = 6'h00, ext_en = 6'h00;
    int          failures = 0, compares = 0;
    // clock and design
    always #5 clock_i = ~clock_i;
    apg_pin_level i_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .addr_parity_end_i(addr_parity_end_i), .reg_rdata_o(reg_rdata_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .tw_sda_o_i(tw_sda_o_i), .tw_scl_o_i(tw_scl_o_i),
        .tw_sda_in_o(tw_sda_in_o));
    apg_ext_pins i_ext (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .level_o(pin_i));
    // one register write, then time for pins and input sync to settle
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock_i);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        repeat (5) @(negedge clock_i);
    endtask : wr
    // address phase of a read: parity end pulse takes the snapshot
    task snap(input logic [7:0] a);
        @(negedge clock_i);
        reg_addr_i        = a;
        addr_parity_end_i = 1'b1;
        @(negedge clock_i);
        addr_parity_end_i = 1'b0;
    endtask : snap
    task chk_rd(input string nm, input logic [15:0] e);
        repeat (2) @(negedge clock_i);
        `CHK(nm, e, reg_rdata_o)
    endtask : chk_rd
    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // watchdog against a hang
    initial begin
        #100us;
        failures++;
        report_and_stop();
    end
    // test sequence
    initial begin
        repeat (4) @(negedge clock_i);
        reset_i = 1'b0;
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("level reset", 16'h0000);
        snap(APG_CFG_REG_ADDR);
        chk_rd("config reset", 16'h3F00);
        `CHK("oe reset", 6'h00, pin_oe_o)
        wr(APG_LEVEL_REG_ADDR, 16'hFFFF);
        `CHK("oe input dir", 6'h00, pin_oe_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("masked write", 16'h3F00);
        wr(APG_CFG_REG_ADDR, 16'h3F3F);
        `CHK("oe output", 6'h3F, pin_oe_o)
        `CHK("out high", 6'h3F, pin_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("drive sense", 16'h3F3F);
        wr(APG_LEVEL_REG_ADDR, 16'h1500);
        `CHK("out mix", 6'h15, pin_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("mix sense", 16'h1515);
        ext_en  = 6'h3F;
        ext_val = 6'h3F;
        wr(APG_CFG_REG_ADDR, 16'h0F3F);
        `CHK("oe analog", 6'h0F, pin_oe_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("analog zero", 16'h1505);
        ext_val = 6'h2A;
        wr(APG_CFG_REG_ADDR, 16'h3F00);
        snap(APG_LEVEL_REG_ADDR);
        ext_val = 6'h15;
        chk_rd("snapshot", 16'h152A);
        // pin 1 held high from outside so the forced zero can show
        ext_val    = 6'h3F;
        tw_sda_o_i = 1'b0;
        wr(APG_CFG_REG_ADDR, 16'hBF3F);
        `CHK("two wire oe", 6'h3D, pin_oe_o)
        `CHK("two wire out", 6'h14, pin_o)
        `CHK("sda in", 1'b0, tw_sda_in_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("two wire read", 16'h1514);
        snap(APG_CFG_REG_ADDR);
        chk_rd("config back", 16'hBF3F);
        // release the data line and pull the clock line low
        tw_sda_o_i = 1'b1;
        tw_scl_o_i = 1'b0;
        repeat (5) @(negedge clock_i);
        `CHK("two wire scl", 6'h3E, pin_oe_o)
        `CHK("sda released", 1'b1, tw_sda_in_o)
        snap(8'h20);
        chk_rd("unmapped", 16'h0000);
        // reset in mid-run: registers return to their reset values
        reset_i = 1'b1;
        repeat (2) @(negedge clock_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clock_i);
        `CHK("oe after reset", 6'h00, pin_oe_o)
        `CHK("out after reset", 6'h00, pin_o)
        snap(APG_LEVEL_REG_ADDR);
        chk_rd("level after reset", 16'h003F);
        snap(APG_CFG_REG_ADDR);
        chk_rd("config after reset", 16'h3F00);
        report_and_stop();
    end
endmodule : tb_top
